// *** design/pli_phy_link.sv ***
// phy side of the packet stream and status interface toward the packet buffer
// Operation
// - a stream beat moves only when valid and ready are both high
// - keep bit seven covers data bits 63:56, bit zero covers 7:0
// - user bit zero on last transmit beat discards the packet
// - receive keep is all ones except on the last beat
// - receive user bit one marks critical flow on first beat when enabled
// - receive user bit zero with last makes the buffer drop the packet
// - host role output follows the host control bit
// - request forward permit follows the master enable control bit
// - long symbol mode output marks six bit identifiers
// - next send index advances per packet sent, reloaded by a rewind
// - last ack index holds the identifier of the latest acknowledge
// - partner free buffers holds the latest received buffer status
`timescale 1ns/1ps
module pli_phy_link (
  input  wire logic                               clk_sys,
  input  wire logic                               reset_n,
  // transmit stream from the buffer
  input  wire logic                               s_axis_phyt_tvalid,
  output logic                                    s_axis_phyt_tready,
  input  wire logic [pli_pkg::DATA_W-1:0]         s_axis_phyt_tdata,
  input  wire logic [pli_pkg::KEEP_W-1:0]         s_axis_phyt_tkeep,
  input  wire logic                               s_axis_phyt_tlast,
  input  wire logic [pli_pkg::USER_W-1:0]         s_axis_phyt_tuser,
  // receive stream to the buffer
  output logic                                    m_axis_phyr_tvalid,
  input  wire logic                               m_axis_phyr_tready,
  output logic [pli_pkg::DATA_W-1:0]              m_axis_phyr_tdata,
  output logic [pli_pkg::KEEP_W-1:0]              m_axis_phyr_tkeep,
  output logic                                    m_axis_phyr_tlast,
  output logic [pli_pkg::USER_W-1:0]              m_axis_phyr_tuser,
  // beats handed to the link framing logic
  output logic                                    lnk_tx_valid,
  input  wire logic                               lnk_tx_ready,
  output logic [pli_pkg::DATA_W-1:0]              lnk_tx_data,
  output logic [pli_pkg::KEEP_W-1:0]              lnk_tx_keep,
  output logic                                    lnk_tx_last,
  output logic                                    lnk_tx_crf,
  output logic                                    lnk_tx_discard,
  // beats arriving from the link framing logic
  input  wire logic                               lnk_rx_valid,
  output logic                                    lnk_rx_ready,
  input  wire logic [pli_pkg::DATA_W-1:0]         lnk_rx_data,
  input  wire logic [pli_pkg::KEEP_W-1:0]         lnk_rx_keep,
  input  wire logic                               lnk_rx_last,
  input  wire logic                               lnk_rx_crf,
  input  wire logic                               lnk_rx_bad,
  // configuration bits and link events
  input  wire logic                               cfg_host,
  input  wire logic                               cfg_master_enable,
  input  wire logic                               cfg_long_mode,
  input  wire logic                               cfg_crf_enable,
  input  wire logic                               ack_rcvd,
  input  wire logic [pli_pkg::ID_W-1:0]           ack_id,
  input  wire logic                               stat_rcvd,
  input  wire logic [pli_pkg::BUF_STAT_W-1:0]     stat_buf,
  input  wire logic                               rewind_req,
  input  wire logic [pli_pkg::ID_W-1:0]           rewind_id,
  // status toward the buffer
  output logic                                    host_role,
  output logic                                    request_forward_permit,
  output logic                                    long_symbol_mode,
  output logic                                    retransmit_req,
  output logic [pli_pkg::ID_W-1:0]                next_send_index,
  output logic [pli_pkg::ID_W-1:0]                last_ack_index,
  output logic [pli_pkg::BUF_STAT_W-1:0]          partner_free_buffers
);

  // identifier width depends on the symbol mode
  function automatic logic [pli_pkg::ID_W-1:0] id_mask(input logic long_mode);
    id_mask = long_mode ? pli_pkg::ID_MASK_LONG : pli_pkg::ID_MASK_SHORT;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta;
  logic rst_n;

  // asynchronous assert, release two edges later on clk_sys
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit slice: one beat deep, ready registered so it never loops combinationally
  logic tx_take, tx_first, tx_done;
  logic next_tx_valid, next_tx_ready, next_tx_first;
  logic [pli_pkg::DATA_W-1:0] next_tx_data;
  logic [pli_pkg::KEEP_W-1:0] next_tx_keep;
  logic next_tx_last, next_tx_crf, next_tx_discard;

  // half throughput is the price of a fully registered ready
  always_comb begin
    tx_take         = s_axis_phyt_tvalid && s_axis_phyt_tready;
    tx_done         = lnk_tx_valid && lnk_tx_ready;
    next_tx_valid   = tx_take || (lnk_tx_valid && !lnk_tx_ready);
    next_tx_ready   = !next_tx_valid;
    next_tx_first   = tx_take ? s_axis_phyt_tlast : tx_first;
    next_tx_data    = lnk_tx_data;
    next_tx_keep    = lnk_tx_keep;
    next_tx_last    = lnk_tx_last;
    next_tx_crf     = lnk_tx_crf;
    next_tx_discard = lnk_tx_discard;
    if (tx_take) begin
      next_tx_data    = s_axis_phyt_tdata;
      next_tx_keep    = s_axis_phyt_tkeep;
      next_tx_last    = s_axis_phyt_tlast;
      next_tx_crf     = tx_first && cfg_crf_enable
                        && s_axis_phyt_tuser[pli_pkg::USER_CRF_BIT];
      next_tx_discard = s_axis_phyt_tlast
                        && s_axis_phyt_tuser[pli_pkg::USER_DISC_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lnk_tx_valid       <= 1'b0;
      s_axis_phyt_tready <= 1'b0;
      tx_first           <= 1'b1;
      lnk_tx_data        <= '0;
      lnk_tx_keep        <= '0;
      lnk_tx_last        <= 1'b0;
      lnk_tx_crf         <= 1'b0;
      lnk_tx_discard     <= 1'b0;
    end else begin
      lnk_tx_valid       <= next_tx_valid;
      s_axis_phyt_tready <= next_tx_ready;
      tx_first           <= next_tx_first;
      lnk_tx_data        <= next_tx_data;
      lnk_tx_keep        <= next_tx_keep;
      lnk_tx_last        <= next_tx_last;
      lnk_tx_crf         <= next_tx_crf;
      lnk_tx_discard     <= next_tx_discard;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive slice toward the buffer
  logic rx_take, rx_first;
  logic next_rx_valid, next_rx_ready, next_rx_first;
  logic [pli_pkg::DATA_W-1:0] next_rx_data;
  logic [pli_pkg::KEEP_W-1:0] next_rx_keep;
  logic next_rx_last;
  logic [pli_pkg::USER_W-1:0] next_rx_user;

  always_comb begin
    rx_take       = lnk_rx_valid && lnk_rx_ready;
    next_rx_valid = rx_take || (m_axis_phyr_tvalid && !m_axis_phyr_tready);
    next_rx_ready = !next_rx_valid;
    next_rx_first = rx_take ? lnk_rx_last : rx_first;
    next_rx_data  = m_axis_phyr_tdata;
    next_rx_keep  = m_axis_phyr_tkeep;
    next_rx_last  = m_axis_phyr_tlast;
    next_rx_user  = m_axis_phyr_tuser;
    if (rx_take) begin
      next_rx_data = lnk_rx_data;
      next_rx_keep = lnk_rx_last ? lnk_rx_keep : pli_pkg::KEEP_ALL;
      next_rx_last = lnk_rx_last;
      next_rx_user = pli_pkg::USER_RESET;
      next_rx_user[pli_pkg::USER_CRF_BIT]  = rx_first && cfg_crf_enable && lnk_rx_crf;
      next_rx_user[pli_pkg::USER_DISC_BIT] = lnk_rx_last && lnk_rx_bad;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      m_axis_phyr_tvalid <= 1'b0;
      lnk_rx_ready       <= 1'b0;
      rx_first           <= 1'b1;
      m_axis_phyr_tdata  <= '0;
      m_axis_phyr_tkeep  <= '0;
      m_axis_phyr_tlast  <= 1'b0;
      m_axis_phyr_tuser  <= pli_pkg::USER_RESET;
    end else begin
      m_axis_phyr_tvalid <= next_rx_valid;
      lnk_rx_ready       <= next_rx_ready;
      rx_first           <= next_rx_first;
      m_axis_phyr_tdata  <= next_rx_data;
      m_axis_phyr_tkeep  <= next_rx_keep;
      m_axis_phyr_tlast  <= next_rx_last;
      m_axis_phyr_tuser  <= next_rx_user;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status toward the buffer
  logic pkt_sent;
  logic [pli_pkg::ID_W-1:0] mask;
  logic [pli_pkg::ID_W-1:0] next_send;
  logic [pli_pkg::ID_W-1:0] next_ack;
  logic [pli_pkg::BUF_STAT_W-1:0] next_stat;

  // a discarded packet never received an identifier, so it does not count
  always_comb begin
    mask      = id_mask(cfg_long_mode);
    pkt_sent  = tx_done && lnk_tx_last && !lnk_tx_discard;
    next_send = next_send_index & mask;
    if (rewind_req) begin
      next_send = rewind_id & mask;
    end else if (pkt_sent) begin
      next_send = (next_send_index + 6'h01) & mask;
    end
    next_ack  = ack_rcvd ? (ack_id & mask) : (last_ack_index & mask);
    next_stat = stat_rcvd ? stat_buf : partner_free_buffers;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      host_role              <= 1'b0;
      request_forward_permit <= 1'b0;
      long_symbol_mode       <= 1'b0;
      retransmit_req         <= 1'b0;
      next_send_index        <= pli_pkg::ID_RESET;
      last_ack_index         <= pli_pkg::ID_RESET;
      partner_free_buffers   <= pli_pkg::BUF_STAT_RESET;
    end else begin
      host_role              <= cfg_host;
      request_forward_permit <= cfg_master_enable;
      long_symbol_mode       <= cfg_long_mode;
      retransmit_req         <= rewind_req;
      next_send_index        <= next_send;
      last_ack_index         <= next_ack;
      partner_free_buffers   <= next_stat;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_tx_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      lnk_tx_valid && !lnk_tx_ready |=> lnk_tx_valid && $stable(lnk_tx_data)
        && $stable(lnk_tx_last);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("link beat changed while stalled");
  property p_rx_keep;
    @(posedge clk_sys) disable iff (!rst_n)
      m_axis_phyr_tvalid && !m_axis_phyr_tlast |-> m_axis_phyr_tkeep == pli_pkg::KEEP_ALL;
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("receive keep not full mid packet");
  property p_rx_crf;
    @(posedge clk_sys) disable iff (!rst_n)
      rx_take && !(rx_first && cfg_crf_enable) |=> !m_axis_phyr_tuser[pli_pkg::USER_CRF_BIT];
  endproperty
  a_rx_crf: assert property (p_rx_crf) else $error("critical flow bit off first beat");
  property p_rx_disc;
    @(posedge clk_sys) disable iff (!rst_n)
      m_axis_phyr_tvalid && m_axis_phyr_tuser[pli_pkg::USER_DISC_BIT] |-> m_axis_phyr_tlast;
  endproperty
  a_rx_disc: assert property (p_rx_disc) else $error("discontinue off the last beat");
  property p_discard;
    @(posedge clk_sys) disable iff (!rst_n)
      tx_done && lnk_tx_discard && !rewind_req |=> $stable(next_send_index)
        || $changed(long_symbol_mode);
  endproperty
  a_discard: assert property (p_discard) else $error("discarded packet advanced index");
  property p_advance;
    @(posedge clk_sys) disable iff (!rst_n)
      pkt_sent && !rewind_req && cfg_long_mode |=>
        next_send_index == $past(next_send_index) + 6'h01;
  endproperty
  a_advance: assert property (p_advance) else $error("next send index did not advance");
  property p_cfg_follow;
    @(posedge clk_sys) disable iff (!rst_n)
      ##1 host_role == $past(cfg_host) && request_forward_permit == $past(cfg_master_enable);
  endproperty
  a_cfg_follow: assert property (p_cfg_follow) else $error("control reflection lags");
  property p_ack;
    @(posedge clk_sys) disable iff (!rst_n)
      ack_rcvd ##1 !ack_rcvd |-> last_ack_index == ($past(ack_id) & $past(mask));
  endproperty
  a_ack: assert property (p_ack) else $error("last ack index not captured");
  property p_stat;
    @(posedge clk_sys) disable iff (!rst_n)
      stat_rcvd |=> partner_free_buffers == $past(stat_buf);
  endproperty
  a_stat: assert property (p_stat) else $error("partner buffer status not captured");
  property p_short_wrap;
    @(posedge clk_sys) disable iff (!rst_n)
      !cfg_long_mode |=> !next_send_index[5] && !last_ack_index[5];
  endproperty
  a_short_wrap: assert property (p_short_wrap) else $error("short mode index above 31");

endmodule

// *** design/pli_pkg.sv ***
// constants shared by the phy link packet interface
package pli_pkg;
  localparam int          DATA_W         = 64;
  localparam int          KEEP_W         = 8;
  localparam int          USER_W         = 8;
  localparam int          ID_W           = 6;
  localparam int          BUF_STAT_W     = 6;
  localparam int          USER_DISC_BIT  = 0;
  localparam int          USER_CRF_BIT   = 1;
  localparam logic [7:0]  KEEP_ALL       = 8'hff;
  localparam logic [5:0]  ID_MASK_SHORT  = 6'h1f;
  localparam logic [5:0]  ID_MASK_LONG   = 6'h3f;
  localparam logic [5:0]  ID_RESET       = 6'h00;
  localparam logic [5:0]  BUF_STAT_RESET = 6'h00;
  localparam logic [7:0]  USER_RESET     = 8'h00;
endpackage

// *** sim/pli_buf_model.sv ***
// packet buffer model facing the phy link packet streams
`timescale 1ns/1ps
module pli_buf_model (
  input  wire logic        clk_sys,
  output logic             s_axis_phyt_tvalid,
  input  wire logic        s_axis_phyt_tready,
  output logic [63:0]      s_axis_phyt_tdata,
  output logic [7:0]       s_axis_phyt_tkeep,
  output logic             s_axis_phyt_tlast,
  output logic [7:0]       s_axis_phyt_tuser,
  input  wire logic        m_axis_phyr_tvalid,
  output logic             m_axis_phyr_tready,
  input  wire logic        m_axis_phyr_tlast,
  input  wire logic [7:0]  m_axis_phyr_tuser,
  input  wire logic        request_forward_permit,
  input  wire logic        retransmit_req,
  input  wire logic [5:0]  next_send_index
);
  logic [15:0] lf;
  logic [5:0]  resend_from;
  int          dropped;
  initial begin
    {s_axis_phyt_tvalid, s_axis_phyt_tdata, s_axis_phyt_tkeep} = '0;
    {s_axis_phyt_tlast, s_axis_phyt_tuser, m_axis_phyr_tready} = '0;
    lf = 16'hace1;
    dropped = 0;
  end
  ////////////////////////////////////////
  // receive side stalls about a quarter of cycles so the phy slice must hold
  always @(posedge clk_sys) begin
    lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    m_axis_phyr_tready <= lf[0] | lf[3];
    if (retransmit_req) resend_from <= next_send_index;
    if (m_axis_phyr_tvalid && m_axis_phyr_tready && m_axis_phyr_tlast && m_axis_phyr_tuser[0])
      dropped <= dropped + 1;
  end
  ////////////////////////////////////////
  // one packet unless req is set without the forward permit, each beat held until the phy takes it
  task automatic send_pkt(input int len, input logic critical_flow_flag, input logic disc, input logic req,
                          input logic [7:0] keep_last, input logic [63:0] d, output logic ok);
    int t;
    ok = 1'b1;
    if (req && !request_forward_permit) return;
    for (int b = 0; b < len; b++) begin
      s_axis_phyt_tvalid <= 1'b1;
      s_axis_phyt_tdata  <= d + 64'(b);
      s_axis_phyt_tkeep  <= (b == len - 1) ? keep_last : 8'hff;
      s_axis_phyt_tlast  <= (b == len - 1);
      s_axis_phyt_tuser  <= {6'h00, critical_flow_flag && b == 0, disc && b == len - 1};
      t = 0;
      do begin
        @(posedge clk_sys);
        t++;
      end while (s_axis_phyt_tready !== 1'b1 && t < 200);
      if (s_axis_phyt_tready !== 1'b1) ok = 1'b0;
    end
    // released data lines show the inverse, never the stale beat
    s_axis_phyt_tvalid <= 1'b0;
    s_axis_phyt_tdata  <= ~s_axis_phyt_tdata;
    @(posedge clk_sys);
  endtask
endmodule

// *** sim/tb.sv ***
// self-checking bench for the phy link packet interface
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb;
  logic        clk_sys, reset_n, s_axis_phyt_tvalid, s_axis_phyt_tready, s_axis_phyt_tlast;
  logic        m_axis_phyr_tvalid, m_axis_phyr_tready, m_axis_phyr_tlast, lnk_tx_valid;
  logic        lnk_tx_ready, lnk_tx_last, lnk_tx_crf, lnk_tx_discard, lnk_rx_valid;
  logic        lnk_rx_ready, lnk_rx_last, lnk_rx_crf, lnk_rx_bad, cfg_host, cfg_master_enable;
  logic        cfg_long_mode, cfg_crf_enable, ack_rcvd, stat_rcvd, rewind_req, host_role;
  logic        request_forward_permit, long_symbol_mode, retransmit_req, ok;
  logic [63:0] s_axis_phyt_tdata, m_axis_phyr_tdata, lnk_tx_data, lnk_rx_data;
  logic [7:0]  s_axis_phyt_tkeep, s_axis_phyt_tuser, m_axis_phyr_tkeep, m_axis_phyr_tuser;
  logic [7:0]  lnk_tx_keep, lnk_rx_keep;
  logic [5:0]  ack_id, stat_buf, rewind_id, next_send_index, last_ack_index;
  logic [5:0]  partner_free_buffers, exp_nsi, m;
  logic [74:0] txq[$], rxq[$], e, o;
  logic [31:0] seed = 32'h00017ac9, r, q2, stall;
  logic        first_t = 1'b1, first_r = 1'b1;
  int          tests_run = 0, error_cnt = 0, n_bad = 0;

  pli_phy_link  pli_phy_link_inst (.*);
  pli_buf_model pli_buf_model_inst (.*);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////
  // link side takes beats at random so the transmit slice has to hold
  always @(posedge clk_sys) begin
    stall = xs();
    lnk_tx_ready <= stall[0] | stall[1];
  end
  // scoreboards: expectation built at each take, compared at each hand-off
  always @(posedge clk_sys) begin
    if (s_axis_phyt_tvalid && s_axis_phyt_tready) begin
      txq.push_back({s_axis_phyt_tdata, s_axis_phyt_tkeep, s_axis_phyt_tlast,
                     first_t & s_axis_phyt_tuser[1] & cfg_crf_enable,
                     s_axis_phyt_tlast & s_axis_phyt_tuser[0]});
      first_t = s_axis_phyt_tlast;
    end
    if (lnk_tx_valid && lnk_tx_ready) begin
      e = txq.size() ? txq.pop_front() : '1;
      o = {lnk_tx_data, lnk_tx_keep, lnk_tx_last, lnk_tx_crf, lnk_tx_discard};
      `CHK("tx beat", e, o)
    end
    if (lnk_rx_valid && lnk_rx_ready) begin
      rxq.push_back({lnk_rx_data, lnk_rx_last ? lnk_rx_keep : 8'hff, lnk_rx_last,
                     first_r & lnk_rx_crf & cfg_crf_enable, lnk_rx_last & lnk_rx_bad});
      first_r = lnk_rx_last;
    end
    if (m_axis_phyr_tvalid && m_axis_phyr_tready) begin
      e = rxq.size() ? rxq.pop_front() : '1;
      o = {m_axis_phyr_tdata, m_axis_phyr_tkeep, m_axis_phyr_tlast, m_axis_phyr_tuser[1:0]};
      `CHK("rx beat", e, o)
      `CHK("rx user", 6'h00, m_axis_phyr_tuser[7:2])
    end
  end
  ////////////////////////////////////////
  // crf and bad held on every beat: only first and last beats may use them
  task automatic rx_pkt(input int len, input logic critical_flow_flag, input logic bad);
    int t;
    logic [31:0] q;
    for (int b = 0; b < len; b++) begin
      q = xs();
      lnk_rx_valid <= 1'b1;
      lnk_rx_data  <= {q, ~q};
      lnk_rx_keep  <= q[7:0];
      lnk_rx_last  <= (b == len - 1);
      lnk_rx_crf   <= critical_flow_flag;
      lnk_rx_bad   <= bad;
      t = 0;
      do begin
        @(posedge clk_sys);
        t++;
      end while (lnk_rx_ready !== 1'b1 && t < 200);
      if (lnk_rx_ready !== 1'b1) begin
        error_cnt++;
        complete_run();
      end
    end
    lnk_rx_valid <= 1'b0;
    lnk_rx_data  <= ~lnk_rx_data;
    @(posedge clk_sys);
  endtask
  ////////////////////////////////////////
  initial begin
    {reset_n, lnk_tx_ready, lnk_rx_valid, lnk_rx_last, lnk_rx_crf, lnk_rx_bad} = '0;
    {lnk_rx_data, lnk_rx_keep, cfg_host, cfg_master_enable, cfg_long_mode} = '0;
    {cfg_crf_enable, ack_rcvd, ack_id, stat_rcvd, stat_buf, rewind_req, rewind_id} = '0;
    repeat (5) @(posedge clk_sys);
    `CHK("nsi in reset", 6'h00, next_send_index)
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    // reflections and link events with random mode and values
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_sys);
      r = xs();
      {cfg_host, cfg_master_enable, cfg_long_mode, cfg_crf_enable} <= r[3:0];
      {ack_rcvd, stat_rcvd, rewind_req} <= 3'h7;
      ack_id    <= r[13:8];
      stat_buf  <= (r[20:16] == 5'h1f) ? 6'h1e : {1'b0, r[20:16]};
      rewind_id <= r[29:24];
      @(posedge clk_sys);
      {ack_rcvd, stat_rcvd, rewind_req} <= 3'h0;
      @(negedge clk_sys);
      `CHK("host", r[3], host_role)
      `CHK("permit", r[2], request_forward_permit)
      `CHK("long", r[1], long_symbol_mode)
      m = r[1] ? 6'h3f : 6'h1f;
      `CHK("ack", r[13:8] & m, last_ack_index)
      `CHK("stat", stat_buf, partner_free_buffers)
      `CHK("nsi rewind", r[29:24] & m, next_send_index)
      `CHK("rewind", 1'b1, retransmit_req)
      @(negedge clk_sys);
      `CHK("rewind end", 1'b0, retransmit_req)
      `CHK("resend", r[29:24] & m, pli_buf_model_inst.resend_from)
    end
    // traffic both ways, index wrapping in each mode
    for (int ph = 0; ph < 2; ph++) begin
      @(posedge clk_sys);
      // first phase withholds the forward permit, so the permit path is exercised
      {cfg_master_enable, cfg_long_mode, cfg_crf_enable} <= {ph == 1, ph == 1, ph == 0};
      rewind_req <= 1'b1;
      rewind_id  <= 6'h3e;
      @(posedge clk_sys);
      rewind_req <= 1'b0;
      // let the permit reflection settle before the buffer looks at it
      @(posedge clk_sys);
      m = (ph == 1) ? 6'h3f : 6'h1f;
      exp_nsi = 6'h3e & m;
      fork
        for (int p = 0; p < 16; p++) begin
          r = xs();
          pli_buf_model_inst.send_pkt(int'(r[1:0]) + 1, r[2], r[3], r[4],
                                      r[15:8] | 8'h01, {r, ~r}, ok);
          if (!ok) begin
            error_cnt++;
            complete_run();
          end
          if (!r[3] && !(r[4] && ph == 0)) exp_nsi = (exp_nsi + 6'h01) & m;
        end
        for (int p = 0; p < 16; p++) begin
          q2 = xs();
          rx_pkt(int'(q2[1:0]) + 1, q2[2], q2[3]);
          n_bad += int'(q2[3]);
        end
      join
      for (int t = 0; t < 300 && (txq.size() || rxq.size()); t++) @(posedge clk_sys);
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK("drain", 0, txq.size() + rxq.size())
      `CHK("nsi", exp_nsi, next_send_index)
      `CHK("drops", n_bad, pli_buf_model_inst.dropped)
    end
    complete_run();
  end
endmodule
